/* File: core/exec_unit.sv */
`timescale 1ns/100ps
// Execution of add, AND, bit set/clear and bit-test-skip instructions
module exec_unit
    import exec_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Instruction cycle enable and decoded instruction
    input  wire logic              cycle_en,
    input  wire instr_s            instr,
    // File register read data for instr.addr
    input  wire logic [DATA_W-1:0] file_rdata,
    // Flags in from the status register
    input  wire flags_s            flags_in,
    // Accumulator and flag state
    output logic      [DATA_W-1:0] acc,
    output flags_s                 flags,
    // File register write
    output fwrite_s                fwrite,
    // Skip: next fetched instruction runs as a no-operation
    output logic                   skip_next,
    output logic                   in_skip
);

    // Operand and results of the arithmetic and bit unit
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] result;
    logic              carry;
    logic              half_carry;
    logic              bit_value;

    // Operation of the current slot
    op_e               eff_op;

    // Next values of the registered state
    logic [DATA_W-1:0] next_acc;
    flags_s            next_flags;
    fwrite_s           next_fwrite;
    logic              next_skip_next;
    logic              next_in_skip;

    // Zero test shared by the add and AND results
    function automatic logic is_zero(input logic [DATA_W-1:0] value);
        is_zero = (value == ZERO_BYTE);
    endfunction : is_zero

    // Combinational arithmetic and bit logic
    alu_unit alu_unit_inst (
        .op         (eff_op),
        .acc        (acc),
        .operand    (operand),
        .bit_sel    (instr.bit_sel),
        .result     (result),
        .carry      (carry),
        .half_carry (half_carry),
        .bit_value  (bit_value)
    );

    // Slot decode; a skipped slot executes as a no-operation,
    // so its file operand and literal are never used
    always_comb begin
        eff_op = in_skip ? op_none : instr.op;
        case (eff_op)
            op_add_literal_to_acc,
            op_and_literal_with_acc: begin
                operand = instr.literal;
            end
            default: begin
                operand = file_rdata;
            end
        endcase
    end

    // Accumulator next value: results whose destination is the accumulator
    always_comb begin
        next_acc = acc;
        if (cycle_en) begin
            case (eff_op)
                // Literal forms always write the accumulator
                op_add_literal_to_acc,
                op_and_literal_with_acc: begin
                    next_acc = result;
                end
                // File forms write it only when the destination bit is 0
                op_add_acc_and_file,
                op_and_acc_with_file: begin
                    if (!instr.dest_file) begin
                        next_acc = result;
                    end
                end
                // Bit operations and tests never touch the accumulator
                op_clear_file_bit,
                op_set_file_bit,
                op_test_bit_skip_if_one,
                op_test_bit_skip_if_zero: begin
                    next_acc = acc;
                end
                default: begin
                    next_acc = acc;
                end
            endcase
        end
    end

    // Accumulator register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc <= ACC_RESET;
        end else begin
            acc <= next_acc;
        end
    end

    // Flags: unaffected bits pass through from the status register,
    // so bit operations and skipped slots leave them as they were
    always_comb begin
        next_flags = flags;
        if (cycle_en) begin
            next_flags = flags_in;
            case (eff_op)
                // Additions also set carry and digit carry
                op_add_literal_to_acc,
                op_add_acc_and_file: begin
                    next_flags.carry            = carry;
                    next_flags.digit_carry_flag = half_carry;
                    next_flags.zero             = is_zero(result);
                end
                // AND results touch only the zero flag
                op_and_literal_with_acc,
                op_and_acc_with_file: begin
                    next_flags.zero = is_zero(result);
                end
                // Bit operations and tests leave every flag as it came in
                op_clear_file_bit,
                op_set_file_bit,
                op_test_bit_skip_if_one,
                op_test_bit_skip_if_zero: begin
                    next_flags = flags_in;
                end
                default: begin
                    next_flags = flags_in;
                end
            endcase
        end
    end

    // Flag register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    // File write: a one-clock pulse after the executing edge
    always_comb begin
        next_fwrite = '0;
        if (cycle_en) begin
            case (eff_op)
                // Byte results go back when the destination bit is 1
                op_add_acc_and_file,
                op_and_acc_with_file: begin
                    next_fwrite.en = instr.dest_file;
                end
                // Bit clear and set always write the whole byte back
                op_clear_file_bit,
                op_set_file_bit: begin
                    next_fwrite.en = 1'b1;
                end
                default: begin
                    next_fwrite.en = 1'b0;
                end
            endcase
            if (next_fwrite.en) begin
                next_fwrite.addr = instr.addr;
                next_fwrite.data = result;
            end
        end
    end

    // File write register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fwrite <= '0;
        end else begin
            fwrite <= next_fwrite;
        end
    end

    // Skip state: the pulse marks a taken test, the level blanks the
    // next slot and is cleared by the enable that runs that slot
    always_comb begin
        next_skip_next = 1'b0;
        next_in_skip   = in_skip;
        if (cycle_en) begin
            next_in_skip = 1'b0;
            case (eff_op)
                // A taken test blanks exactly one following slot
                op_test_bit_skip_if_one: begin
                    next_skip_next = bit_value;
                    next_in_skip   = bit_value;
                end
                op_test_bit_skip_if_zero: begin
                    next_skip_next = ~bit_value;
                    next_in_skip   = ~bit_value;
                end
                default: begin
                    next_skip_next = 1'b0;
                end
            endcase
        end
    end

    // Skip registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            skip_next <= 1'b0;
            in_skip   <= 1'b0;
        end else begin
            skip_next <= next_skip_next;
            in_skip   <= next_in_skip;
        end
    end

endmodule : exec_unit

/* File: core/exec_pkg.sv */
// Notes on behaviour
// - Add literal to accumulator; carry, digit carry, zero
// - Add accumulator and file, destination bit selects
// - AND literal into accumulator, only Z changes
// - AND accumulator with file, destination selects, Z only
// - Clear chosen file bit, flags untouched
// - Set chosen file bit, flags untouched
// - Skip next instruction when tested bit one
// - Skip next instruction when tested bit zero
package exec_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int BIT_W  = 3;
    localparam int NIB_W  = 4;

    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    // Operation selected by the decoder
    typedef enum logic [3:0] {
        op_none,
        op_add_literal_to_acc,
        op_add_acc_and_file,
        op_and_literal_with_acc,
        op_and_acc_with_file,
        op_clear_file_bit,
        op_set_file_bit,
        op_test_bit_skip_if_one,
        op_test_bit_skip_if_zero
    } op_e;

    // Decoded instruction presented for one instruction cycle
    typedef struct packed {
        op_e               op;
        logic [DATA_W-1:0] literal;
        logic [ADDR_W-1:0] addr;
        logic [BIT_W-1:0]  bit_sel;
        logic              dest_file;
    } instr_s;

    // Status flags touched by this block
    typedef struct packed {
        logic carry;
        logic digit_carry_flag;
        logic zero;
    } flags_s;

    // File register write request
    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fwrite_s;

endpackage : exec_pkg

/* File: core/alu_unit.sv */
`timescale 1ns/100ps
// Combinational arithmetic and bit logic
module alu_unit
    import exec_pkg::*;
(
    // Operands
    input  wire op_e               op,
    input  wire logic [DATA_W-1:0] acc,
    input  wire logic [DATA_W-1:0] operand,
    input  wire logic [BIT_W-1:0]  bit_sel,
    // Results
    output logic      [DATA_W-1:0] result,
    output logic                   carry,
    output logic                   half_carry,
    output logic                   bit_value
);

    // Sum with carry out of a given width
    function automatic logic [DATA_W:0] add_full(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
        add_full = {1'b0, a} + {1'b0, b};
    endfunction : add_full

    function automatic logic [NIB_W:0] add_nib(input logic [NIB_W-1:0] a, input logic [NIB_W-1:0] b);
        add_nib = {1'b0, a} + {1'b0, b};
    endfunction : add_nib

    logic [DATA_W:0] sum;
    logic [NIB_W:0]  nib;
    logic [DATA_W-1:0] mask;

    // Result selection per operation
    always_comb begin
        sum        = add_full(acc, operand);
        nib        = add_nib(acc[NIB_W-1:0], operand[NIB_W-1:0]);
        mask       = 8'h01 << bit_sel;
        carry      = sum[DATA_W];
        half_carry = nib[NIB_W];
        bit_value  = operand[bit_sel];
        case (op)
            op_add_literal_to_acc,
            op_add_acc_and_file:     result = sum[DATA_W-1:0];
            op_and_literal_with_acc,
            op_and_acc_with_file:    result = acc & operand;
            op_clear_file_bit:       result = operand & ~mask;
            op_set_file_bit:         result = operand | mask;
            default:                 result = operand;
        endcase
    end

endmodule : alu_unit

/* File: dv/exec_unit_assertions.sv */
`timescale 1ns/100ps
// Watches the execution unit ports
module exec_checker
    import exec_pkg::*;
(
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              cycle_en,
    input wire instr_s            instr,
    input wire logic [DATA_W-1:0] file_rdata,
    input wire flags_s            flags_in,
    input wire logic [DATA_W-1:0] acc,
    input wire flags_s            flags,
    input wire fwrite_s           fwrite,
    input wire logic              skip_next,
    input wire logic              in_skip
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Instruction really executed on this edge
    wire go = cycle_en && !in_skip;
    add_lit_a: assert property (go && instr.op == op_add_literal_to_acc |=>
        {flags.carry, acc} == {1'b0, $past(acc)} + $past(instr.literal)) else $error("add literal wrong");
    add_flags_a: assert property (go && instr.op == op_add_literal_to_acc |=> flags.zero == (acc == 8'h00) &&
        flags.digit_carry_flag == (($past(acc[3:0]) + $past(instr.literal[3:0])) > 15)) else $error("add flags wrong");
    add_file_a: assert property (go && instr.op == op_add_acc_and_file && instr.dest_file |=>
        fwrite.en && fwrite.data == $past(acc) + $past(file_rdata) && acc == $past(acc)) else $error("add file wrong");
    and_lit_a: assert property (go && instr.op == op_and_literal_with_acc |=>
        acc == ($past(acc) & $past(instr.literal)) && flags.carry == $past(flags_in.carry)) else $error("and wrong");
    and_file_a: assert property (go && instr.op == op_and_acc_with_file && !instr.dest_file |=>
        acc == ($past(acc) & $past(file_rdata)) && !fwrite.en) else $error("and file wrong");
    clr_bit_a: assert property (go && instr.op == op_clear_file_bit |=> flags == $past(flags_in) &&
        fwrite.data == ($past(file_rdata) & ~(8'h01 << $past(instr.bit_sel)))) else $error("bit clear wrong");
    set_bit_a: assert property (go && instr.op == op_set_file_bit |=> fwrite.en &&
        fwrite.data == ($past(file_rdata) | (8'h01 << $past(instr.bit_sel)))) else $error("bit set wrong");
    skip_one_a: assert property (go && instr.op == op_test_bit_skip_if_one |=>
        skip_next == $past(file_rdata[instr.bit_sel])) else $error("skip if one wrong");
    skip_zero_a: assert property (go && instr.op == op_test_bit_skip_if_zero |=>
        skip_next == !$past(file_rdata[instr.bit_sel])) else $error("skip if zero wrong");
    skipped_a: assert property (cycle_en && in_skip |=> acc == $past(acc) && !fwrite.en && !skip_next && !in_skip)
        else $error("skipped cycle changed state");
endmodule : exec_checker

bind exec_unit exec_checker exec_checker_inst (.clk(clk), .rstn(rstn), .cycle_en(cycle_en), .instr(instr),
    .file_rdata(file_rdata), .flags_in(flags_in), .acc(acc), .flags(flags), .fwrite(fwrite),
    .skip_next(skip_next), .in_skip(in_skip));

/* File: dv/exec_unit_tb_top.sv */
`timescale 1ns/100ps
module exec_unit_tb_top import exec_pkg::*;;
    logic              clk        = 1'b0;
    logic              rstn       = 1'b0;
    logic              cycle_en   = 1'b0;
    instr_s            instr      = '0;
    logic [DATA_W-1:0] file_rdata = 8'h00;
    flags_s            flags_in   = '0;
    logic [DATA_W-1:0] acc;
    flags_s            flags;
    fwrite_s           fwrite;
    logic              skip_next;
    logic              in_skip;
    int                n_fail     = 0;
    int                n_checks   = 0;
    always #20 clk = ~clk;
    exec_unit exec_unit_inst (.clk(clk), .rstn(rstn), .cycle_en(cycle_en), .instr(instr), .file_rdata(file_rdata),
        .flags_in(flags_in), .acc(acc), .flags(flags), .fwrite(fwrite), .skip_next(skip_next), .in_skip(in_skip));
    // Compare one result value
    task automatic chk(string name, logic [8:0] exp, logic [8:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // One instruction cycle; results are read half a clock after it
    task automatic ex(op_e op, logic [7:0] lit, logic [7:0] rd, logic [2:0] b, logic d);
        @(negedge clk);
        cycle_en = 1'b1;
        instr = '{op, lit, 7'h7F, b, d};
        file_rdata = rd;
        @(negedge clk);
        cycle_en = 1'b0;
    endtask : ex
    task automatic t_add_lit();
        ex(op_add_literal_to_acc, 8'hFF, 8'h00, 3'h0, 1'b0);
        chk("add lit", 9'h0FF, {flags.carry, acc});
        ex(op_add_literal_to_acc, 8'h01, 8'h00, 3'h0, 1'b0);
        chk("add lit wrap", 9'h100, {flags.carry, acc});
        chk("dc and zero", 9'h003, {flags.digit_carry_flag, flags.zero});
    endtask : t_add_lit
    task automatic t_add_file();
        ex(op_add_literal_to_acc, 8'h01, 8'h00, 3'h0, 1'b0);
        ex(op_add_acc_and_file, 8'h00, 8'h0F, 3'h0, 1'b1);
        chk("add to file", 9'h110, {fwrite.en, fwrite.data});
        chk("write addr", 9'h07F, fwrite.addr);
        chk("acc kept", 9'h001, acc);
        chk("dc", 9'h001, flags.digit_carry_flag);
        ex(op_add_acc_and_file, 8'h00, 8'h80, 3'h0, 1'b0);
        chk("add to acc", 9'h081, {fwrite.en, acc});
    endtask : t_add_file
    task automatic t_and();
        flags_in = '{1'b1, 1'b0, 1'b0};
        ex(op_and_literal_with_acc, 8'h0F, 8'h00, 3'h0, 1'b0);
        chk("and lit", 9'h101, {flags.carry, acc});
        ex(op_and_acc_with_file, 8'h00, 8'h00, 3'h0, 1'b1);
        chk("and to file", 9'h100, {fwrite.en, fwrite.data});
        chk("and zero", 9'h101, {flags.zero, acc});
        ex(op_and_acc_with_file, 8'h00, 8'hFF, 3'h0, 1'b0);
        chk("and to acc", 9'h001, {flags.zero, acc});
    endtask : t_and
    task automatic t_bits();
        flags_in = '{1'b1, 1'b0, 1'b1};
        for (int b = 0; b < 8; b++) begin
            ex(op_clear_file_bit, 8'h00, 8'hFF, 3'(b), 1'b0);
            chk("bit clear", {1'b1, ~(8'h01 << b)}, {fwrite.en, fwrite.data});
            chk("clear flags", 9'h005, flags);
            ex(op_set_file_bit, 8'h00, 8'h00, 3'(b), 1'b0);
            chk("bit set", {1'b1, 8'h01 << b}, {fwrite.en, fwrite.data});
            chk("set flags", 9'h005, flags);
        end
        flags_in = '0;
    endtask : t_bits
    task automatic t_skip();
        logic [7:0] a;
        logic       sk;
        for (int k = 0; k < 4; k++) begin
            sk = k[1] ? k[0] : !k[0];
            ex(k[1] ? op_test_bit_skip_if_one : op_test_bit_skip_if_zero, 8'h00, k[0] ? 8'h08 : 8'hF7, 3'h3, 1'b0);
            chk("skip", {7'h00, sk, sk}, {skip_next, in_skip});
            a = acc;
            ex(op_add_literal_to_acc, 8'h01, 8'h00, 3'h0, 1'b0);
            chk("after skip", sk ? a : 8'(a + 8'h01), acc);
        end
    endtask : t_skip
    // Report the counts and end the run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        t_add_lit();
        t_add_file();
        t_and();
        t_bits();
        t_skip();
        give_verdict();
    end
    // Cuts a hang short
    initial begin
        #100000;
        n_fail++;
        give_verdict();
    end
endmodule : exec_unit_tb_top
